//--- logic/scs_sched.sv
/*
  SDRAM command scheduler: command queue, per-master and global reordering,
  refresh interleave, self-refresh entry, resets and a Wishbone register slave.
  Assumes a refresh timer supplies urgency levels, an SDRAM sequencer takes
  issued commands, and the read data path reports each word it hands out.
*/
`timescale 1ns/10ps
`default_nettype none

module scs_sched (
  // clock and resets
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_state_machine_reset_n,
  input wire logic i_pll_release,
  // register bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // command requests
  input wire logic i_cmd_valid,
  input wire scs_pkg::scs_cmd_t i_cmd,
  output logic o_cmd_ready,
  // refresh urgency and read data drain
  input wire logic i_ref_must,
  input wire logic i_ref_need,
  input wire logic i_ref_may,
  input wire logic i_rdq_pop,
  // issued commands
  output logic o_iss_valid,
  output scs_pkg::scs_iss_t o_iss,
  input wire logic i_iss_ready,
  // status
  output logic o_init_busy,
  output logic o_self_refresh,
  output logic o_dma_req
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [2:0] eff_prio(input scs_pkg::scs_entry_t e);
    return e.boost ? scs_pkg::SCS_PRIO_MAX : e.cmd.prio;
  endfunction

  function automatic logic row_hit(input scs_pkg::scs_entry_t e,
                                   input logic [3:0] vld, input scs_pkg::scs_rows_t rows);
    logic [1:0] bank;
    bank = e.cmd.addr[scs_pkg::SCS_BANK_LSB +: scs_pkg::SCS_BANK_W];
    return vld[bank] && rows[bank] == e.cmd.addr[scs_pkg::SCS_ROW_LSB +: scs_pkg::SCS_ROW_W];
  endfunction

  // per-master candidate as {valid, index}
  function automatic logic [3:0] pick_master(input scs_pkg::scs_queue_t q,
                                             input logic [2:0] n, input logic [1:0] m);
    logic found;
    logic rfound;
    logic ok;
    logic [2:0] old;
    logic [2:0] rd;
    found = 1'b0;
    rfound = 1'b0;
    ok = 1'b1;
    old = 3'h0;
    rd = 3'h0;
    for (int i = 0; i < scs_pkg::SCS_QDEPTH; i++) begin
      if (3'(i) < n && q[i].cmd.master == m) begin
        if (!found) begin
          found = 1'b1;
          old = 3'(i);
        end
        if (!q[i].cmd.wr && !rfound) begin
          rfound = 1'b1;
          rd = 3'(i);
        end
      end
    end
    // only the first read may overtake, so reads stay in order
    for (int k = 0; k < scs_pkg::SCS_QDEPTH; k++) begin
      if (3'(k) < rd && q[k].cmd.master == m && q[k].cmd.wr) begin
        if (q[k].cmd.addr[31:scs_pkg::SCS_BLK_LSB] == q[rd].cmd.addr[31:scs_pkg::SCS_BLK_LSB]
            || eff_prio(q[rd]) < eff_prio(q[k])) begin
          ok = 1'b0;
        end
      end
    end
    if (rfound && ok) begin
      return {1'b1, rd};
    end
    return {found, old};
  endfunction

  // global choice among master candidates of one direction
  function automatic logic [3:0] pick_global(input scs_pkg::scs_queue_t q,
                                             input logic [3:0][3:0] cand, input logic want_wr,
                                             input logic [3:0] vld, input scs_pkg::scs_rows_t rows);
    logic any_hit;
    logic [3:0] best;
    logic [2:0] c;
    any_hit = 1'b0;
    best = 4'h0;
    c = 3'h0;
    for (int m = 0; m < scs_pkg::SCS_NMASTER; m++) begin
      c = cand[m][2:0];
      if (cand[m][3] && q[c].cmd.wr == want_wr && row_hit(q[c], vld, rows)) begin
        any_hit = 1'b1;
      end
    end
    for (int m = 0; m < scs_pkg::SCS_NMASTER; m++) begin
      c = cand[m][2:0];
      if (cand[m][3] && q[c].cmd.wr == want_wr && (!any_hit || row_hit(q[c], vld, rows))) begin
        if (!best[3] || eff_prio(q[c]) > eff_prio(q[best[2:0]])
            || (eff_prio(q[c]) == eff_prio(q[best[2:0]]) && c < best[2:0])) begin
          best = {1'b1, c};
        end
      end
    end
    return best;
  endfunction

  // ****************************************************************
  // state and candidates
  // ****************************************************************
  scs_pkg::scs_state_t s_r;
  scs_pkg::scs_state_t s_nxt;
  wire logic [3:0][3:0] cand;
  logic acc;
  logic trap;
  logic wb_req;
  logic wr_pend;
  logic hold_ack;
  logic iss_free;
  logic iss_go;
  logic rw_go;
  logic rd_ok;
  logic raise;
  logic in_rst;
  logic [3:0] rsel;
  logic [3:0] wsel;
  logic [2:0] go_idx;
  logic [2:0] qc;
  logic [1:0] bank;
  scs_pkg::scs_kind_t go_kind;
  scs_pkg::scs_queue_t qn;

  // one candidate per master at most
  for (genvar m = 0; m < scs_pkg::SCS_NMASTER; m++) begin : g_cand
    assign cand[m] = pick_master(s_r.core.q, s_r.core.qcnt, 2'(m));
  end

  assign in_rst = !i_state_machine_reset_n || !i_pll_release;
  assign o_cmd_ready = s_r.core.st != scs_pkg::SCS_S_INIT && !in_rst
    && s_r.core.qcnt < scs_pkg::SCS_Q_FULL
    && (!i_cmd.wr || s_r.core.wdq_cnt < scs_pkg::SCS_WDQ_FULL);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    qn = s_r.core.q;
    qc = s_r.core.qcnt;
    go_kind = scs_pkg::SCS_K_READ;
    go_idx = 3'h0;
    iss_go = 1'b0;
    bank = 2'h0;

    // register bus; a status read waits for pending writes to leave
    wb_req = i_wb_cyc && i_wb_stb && !s_r.bus.ack;
    wr_pend = s_r.core.iss_valid && s_r.core.iss.kind == scs_pkg::SCS_K_WRITE;
    for (int i = 0; i < scs_pkg::SCS_QDEPTH; i++) begin
      if (3'(i) < s_r.core.qcnt && s_r.core.q[i].cmd.wr) begin
        wr_pend = 1'b1;
      end
    end
    hold_ack = !i_wb_we && i_wb_adr == scs_pkg::SCS_OFS_STATUS && wr_pend;
    s_nxt.bus.ack = wb_req && !hold_ack;
    if (s_nxt.bus.ack) begin
      case (i_wb_adr)
        scs_pkg::SCS_OFS_STATUS: s_nxt.bus.rdat = {16'h0000, s_r.core.wdq_cnt,
          s_r.core.rdq_cnt, 1'b0, s_r.core.qcnt, 2'h0,
          s_r.core.st == scs_pkg::SCS_S_SREF, s_r.core.st == scs_pkg::SCS_S_INIT};
        scs_pkg::SCS_OFS_REFCTL: s_nxt.bus.rdat = {s_r.regs.lp_en, s_r.regs.sr_sel, 30'h0};
        scs_pkg::SCS_OFS_BURST_PRIORITY_REG: s_nxt.bus.rdat = {24'h000000, s_r.regs.starve};
        scs_pkg::SCS_OFS_RAWIRQ: s_nxt.bus.rdat = {31'h0, s_r.regs.line_trap};
        default: s_nxt.bus.rdat = 32'h0000_0000;
      endcase
      // registers take full-word writes only
      if (i_wb_we && i_wb_sel == 4'hF) begin
        case (i_wb_adr)
          scs_pkg::SCS_OFS_REFCTL: begin
            s_nxt.regs.lp_en = i_wb_dat[scs_pkg::SCS_REFCTL_LP_BIT];
            s_nxt.regs.sr_sel = i_wb_dat[scs_pkg::SCS_REFCTL_SEL_BIT];
          end
          scs_pkg::SCS_OFS_BURST_PRIORITY_REG:
            s_nxt.regs.starve = i_wb_dat[scs_pkg::SCS_BURST_PRIORITY_REG_STARVE_LSB +: 8];
          scs_pkg::SCS_OFS_RAWIRQ:
            if (i_wb_dat[scs_pkg::SCS_RAWIRQ_LT_BIT]) begin
              s_nxt.regs.line_trap = 1'b0;
            end
          default: ;
        endcase
      end
    end

    // request intake; the trap set below wins over a same-cycle clear
    acc = i_cmd_valid && o_cmd_ready;
    trap = i_cmd.burst != scs_pkg::SCS_BURST_LINEAR && i_cmd.burst != scs_pkg::SCS_BURST_WRAP;
    if (acc && trap) begin
      s_nxt.regs.line_trap = 1'b1;
    end

    // issue slot
    if (s_r.core.iss_valid && i_iss_ready) begin
      s_nxt.core.iss_valid = 1'b0;
    end
    iss_free = !s_r.core.iss_valid || i_iss_ready;
    rsel = pick_global(s_r.core.q, cand, 1'b0, s_r.core.open_vld, s_r.core.open_row);
    wsel = pick_global(s_r.core.q, cand, 1'b1, s_r.core.open_vld, s_r.core.open_row);
    rd_ok = rsel[3] && s_r.core.rdq_cnt < scs_pkg::SCS_RDQ_FULL
      && !(wsel[3] && eff_prio(s_r.core.q[wsel[2:0]]) > eff_prio(s_r.core.q[rsel[2:0]]));

    case (s_r.core.st)
      scs_pkg::SCS_S_INIT: begin
        if (s_r.core.init_cnt == 8'h00) begin
          s_nxt.core.st = scs_pkg::SCS_S_RUN;
        end else begin
          s_nxt.core.init_cnt = s_r.core.init_cnt - 8'h01;
        end
      end
      scs_pkg::SCS_S_RUN: begin
        // refresh waits for its urgency level
        if (iss_free) begin
          iss_go = 1'b1;
          if (i_ref_must) begin
            go_kind = scs_pkg::SCS_K_REFRESH;
          end else if (rd_ok) begin
            go_idx = rsel[2:0];
          end else if (i_ref_need) begin
            go_kind = scs_pkg::SCS_K_REFRESH;
          end else if (wsel[3]) begin
            go_kind = scs_pkg::SCS_K_WRITE;
            go_idx = wsel[2:0];
          end else if (i_ref_may) begin
            go_kind = scs_pkg::SCS_K_REFRESH;
          end else if (s_r.regs.lp_en && !s_r.regs.sr_sel && s_r.core.qcnt == 3'h0) begin
            go_kind = scs_pkg::SCS_K_SR_ENTER;
            s_nxt.core.st = scs_pkg::SCS_S_SREF;
          end else begin
            iss_go = 1'b0;
          end
        end
      end
      scs_pkg::SCS_S_SREF: begin
        // the memory refreshes itself here; queued commands wait for the exit
        if (iss_free && !s_r.regs.lp_en) begin
          iss_go = 1'b1;
          go_kind = scs_pkg::SCS_K_SR_EXIT;
          s_nxt.core.st = scs_pkg::SCS_S_RUN;
        end
      end
      default: s_nxt.core.st = scs_pkg::SCS_S_INIT;
    endcase

    rw_go = iss_go && (go_kind == scs_pkg::SCS_K_READ || go_kind == scs_pkg::SCS_K_WRITE);
    if (iss_go) begin
      s_nxt.core.iss_valid = 1'b1;
      s_nxt.core.iss.kind = go_kind;
      s_nxt.core.iss.cmd = rw_go ? s_r.core.q[go_idx].cmd : '0;
      if (!rw_go) begin
        s_nxt.core.open_vld = '0;
      end
    end
    if (rw_go) begin
      bank = s_r.core.q[go_idx].cmd.addr[scs_pkg::SCS_BANK_LSB +: scs_pkg::SCS_BANK_W];
      s_nxt.core.open_vld[bank] = 1'b1;
      s_nxt.core.open_row[bank] =
        s_r.core.q[go_idx].cmd.addr[scs_pkg::SCS_ROW_LSB +: scs_pkg::SCS_ROW_W];
      // close the gap so index 0 stays the oldest entry
      for (int i = 0; i < scs_pkg::SCS_QDEPTH - 1; i++) begin
        if (3'(i) >= go_idx) begin
          qn[i] = s_r.core.q[i + 1];
        end
      end
      qn[scs_pkg::SCS_QDEPTH - 1] = '0;
      qc = qc - 3'h1;
    end

    // data queue occupancy
    s_nxt.core.rdq_cnt = s_r.core.rdq_cnt
      + 4'(rw_go && go_kind == scs_pkg::SCS_K_READ)
      - 4'(i_rdq_pop && s_r.core.rdq_cnt != 4'h0);
    s_nxt.core.wdq_cnt = s_r.core.wdq_cnt + 4'(acc && i_cmd.wr)
      - 4'(rw_go && go_kind == scs_pkg::SCS_K_WRITE);

    if (acc) begin
      qn[qc].boost = 1'b0;
      qn[qc].cmd = i_cmd;
      if (trap) begin
        qn[qc].cmd.burst = scs_pkg::SCS_BURST_LINEAR;
      end
      qc = qc + 3'h1;
    end

    // starvation relief
    raise = rw_go && s_r.regs.starve != 8'h00 && s_r.core.xfer_cnt + 8'h01 >= s_r.regs.starve;
    if (raise) begin
      s_nxt.core.xfer_cnt = 8'h00;
      if (qc != 3'h0) begin
        qn[0].boost = 1'b1;
      end
    end else if (rw_go) begin
      s_nxt.core.xfer_cnt = s_r.core.xfer_cnt + 8'h01;
    end
    s_nxt.core.q = qn;
    s_nxt.core.qcnt = qc;

    // machine-only reset leaves the registers alone
    if (in_rst) begin
      s_nxt.core = scs_pkg::SCS_CORE_RST;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= scs_pkg::SCS_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_wb_dat = s_r.bus.rdat;
  assign o_wb_ack = s_r.bus.ack;
  assign o_iss_valid = s_r.core.iss_valid;
  assign o_iss = s_r.core.iss;
  assign o_init_busy = s_r.core.st == scs_pkg::SCS_S_INIT;
  assign o_self_refresh = s_r.core.st == scs_pkg::SCS_S_SREF;
  assign o_dma_req = 1'b0;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_queue_cap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_r.core.qcnt == scs_pkg::SCS_Q_FULL |-> !o_cmd_ready)
    else $error("command accepted into a full queue");

  a_queue_grow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    acc && !rw_go && !in_rst |=> s_r.core.qcnt == $past(s_r.core.qcnt) + 3'h1)
    else $error("accepted command not queued");

  a_must_first: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_self_refresh == 1'b0 && !o_init_busy && iss_free && i_ref_must && !in_rst
    |=> o_iss_valid && o_iss.kind == scs_pkg::SCS_K_REFRESH)
    else $error("urgent refresh not issued first");

  a_read_full: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_r.core.rdq_cnt == scs_pkg::SCS_RDQ_FULL |-> !(iss_go && go_kind == scs_pkg::SCS_K_READ))
    else $error("read issued with full read data queue");

  a_starve_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    raise && !in_rst |=> s_r.core.xfer_cnt == 8'h00 ##1 s_r.core.xfer_cnt <= 8'h01)
    else $error("transfer counter not restarted after raise");

  a_trap_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    acc && trap |=> s_r.regs.line_trap && s_r.core.q[$past(qc) - 3'h1].cmd.burst == 2'h0)
    else $error("unsupported burst not trapped");

  a_sm_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_state_machine_reset_n && !i_wb_cyc
    |=> o_init_busy && s_r.core.qcnt == 3'h0 && $stable(s_r.regs))
    else $error("machine reset disturbed registers or kept commands");

  a_status_wait: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wb_req && hold_ack |=> !o_wb_ack)
    else $error("status read answered with writes pending");

  a_sre_empty: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    iss_go && go_kind == scs_pkg::SCS_K_SR_ENTER |-> s_r.core.qcnt == 3'h0 && !s_r.regs.sr_sel)
    else $error("self-refresh entered with work queued");

endmodule

`default_nettype wire

//--- logic/scs_pkg.sv
/*
  Shared constants and carrier types of the SDRAM command scheduler.
  Assumes one 100 MHz clock domain. Register offsets are byte addresses
  on a 32-bit Wishbone slave.
*/
`default_nettype none

package scs_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int SCS_QDEPTH = 7;
  localparam int SCS_WDQ_DEPTH = 11;
  localparam int SCS_RDQ_DEPTH = 15;
  localparam int SCS_NMASTER = 4;
  localparam logic [2:0] SCS_Q_FULL = 3'(SCS_QDEPTH);
  localparam logic [3:0] SCS_WDQ_FULL = 4'(SCS_WDQ_DEPTH);
  localparam logic [3:0] SCS_RDQ_FULL = 4'(SCS_RDQ_DEPTH);

  // ****************************************************************
  // address fields
  // ****************************************************************
  localparam int SCS_BLK_LSB = 11;
  localparam int SCS_BANK_LSB = 11;
  localparam int SCS_BANK_W = 2;
  localparam int SCS_ROW_LSB = 13;
  localparam int SCS_ROW_W = 14;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SCS_CLK_MHZ = 100;
  localparam int SCS_INIT_NS = 1000;
  localparam int SCS_INIT_CYC = (SCS_INIT_NS * SCS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SCS_INIT_CNT = 8'(SCS_INIT_CYC - 1);

  // ****************************************************************
  // registers
  // ****************************************************************
  localparam logic [7:0] SCS_OFS_STATUS = 8'h04;
  localparam logic [7:0] SCS_OFS_REFCTL = 8'h0C;
  localparam logic [7:0] SCS_OFS_BURST_PRIORITY_REG = 8'h20;
  localparam logic [7:0] SCS_OFS_RAWIRQ = 8'hC0;
  localparam int SCS_REFCTL_LP_BIT = 31;
  localparam int SCS_REFCTL_SEL_BIT = 30;
  localparam int SCS_BURST_PRIORITY_REG_STARVE_LSB = 0;
  localparam int SCS_RAWIRQ_LT_BIT = 0;
  localparam logic [7:0] SCS_STARVE_RST = 8'h10;
  localparam logic [1:0] SCS_BURST_LINEAR = 2'h0;
  localparam logic [1:0] SCS_BURST_WRAP = 2'h1;
  localparam logic [2:0] SCS_PRIO_MAX = 3'h7;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    SCS_K_READ, SCS_K_WRITE, SCS_K_REFRESH, SCS_K_SR_ENTER, SCS_K_SR_EXIT
  } scs_kind_t;

  typedef enum logic [1:0] {SCS_S_INIT, SCS_S_RUN, SCS_S_SREF} scs_fsm_t;

  typedef struct packed {
    logic [1:0] master;
    logic wr;
    logic [2:0] prio;
    logic [1:0] burst;
    logic [31:0] addr;
  } scs_cmd_t;

  typedef struct packed {
    logic boost;
    scs_cmd_t cmd;
  } scs_entry_t;

  typedef scs_entry_t [SCS_QDEPTH-1:0] scs_queue_t;
  typedef logic [(1 << SCS_BANK_W)-1:0][SCS_ROW_W-1:0] scs_rows_t;

  typedef struct packed {
    scs_kind_t kind;
    scs_cmd_t cmd;
  } scs_iss_t;

  typedef struct packed {
    logic lp_en;
    logic sr_sel;
    logic [7:0] starve;
    logic line_trap;
  } scs_regs_t;

  typedef struct packed {
    scs_fsm_t st;
    logic [7:0] init_cnt;
    scs_queue_t q;
    logic [2:0] qcnt;
    logic [(1 << SCS_BANK_W)-1:0] open_vld;
    scs_rows_t open_row;
    logic [7:0] xfer_cnt;
    logic [3:0] rdq_cnt;
    logic [3:0] wdq_cnt;
    logic iss_valid;
    scs_iss_t iss;
  } scs_core_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
  } scs_bus_t;

  typedef struct packed {
    scs_regs_t regs;
    scs_core_t core;
    scs_bus_t bus;
  } scs_state_t;

  localparam scs_core_t SCS_CORE_RST = '{st: SCS_S_INIT, init_cnt: SCS_INIT_CNT, q: '0,
    qcnt: 3'h0, open_vld: '0, open_row: '0, xfer_cnt: 8'h00, rdq_cnt: 4'h0,
    wdq_cnt: 4'h0, iss_valid: 1'b0, iss: '{kind: SCS_K_READ, cmd: '0}};
  localparam scs_regs_t SCS_REGS_RST = '{lp_en: 1'b0, sr_sel: 1'b0,
    starve: SCS_STARVE_RST, line_trap: 1'b0};
  localparam scs_state_t SCS_STATE_RST = '{regs: SCS_REGS_RST, core: SCS_CORE_RST,
    bus: '{ack: 1'b0, rdat: 32'h0000_0000}};

endpackage

`default_nettype wire

//--- test/scs_seq_model.sv
/*
  Stand-in for the sdram sequencer behind the issue port.
  Assumes the bench drives i_stall just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module scs_seq_model (
  // clock and control
  input wire logic i_ref_clk,
  input wire logic i_stall,
  // issue side
  input wire logic i_iss_valid,
  input wire scs_pkg::scs_iss_t i_iss,
  output logic o_iss_ready,
  output logic o_rdq_pop
);
  logic [3:0] words_r = 4'h0;
  logic pop_r = 1'b0;

  assign o_iss_ready = !i_stall;
  assign o_rdq_pop = pop_r;

  // drain one read word every other cycle; a stall also holds the drain
  always_ff @(posedge i_ref_clk) begin
    // a take and a pop in one cycle cancel out
    words_r <= words_r + 4'(o_iss_ready && i_iss_valid && i_iss.kind == scs_pkg::SCS_K_READ)
      - 4'(pop_r);
    pop_r <= !i_stall && !pop_r && words_r != 4'h0;
  end
endmodule

`default_nettype wire

//--- test/scs_sched_tb.sv
/*
  Bench of the command scheduler: registers, ordering, trap, self-refresh, resets.
  Assumes the sequencer stand-in of scs_seq_model.
*/
`timescale 1ns/10ps
`default_nettype none

module scs_sched_tb;
  logic i_ref_clk, rst_n, sm_rst_n, pll, cyc, stb, we, cval, stall, rmust;
  logic ack, crdy, ivld, irdy, pop, busy, sref, dma;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, o_dat;
  scs_pkg::scs_cmd_t cmd;
  scs_pkg::scs_iss_t iss;
  scs_pkg::scs_iss_t got[$];
  int failures, checks;

  scs_sched uut (.i_ref_clk(i_ref_clk), .i_rst_n(rst_n), .i_state_machine_reset_n(sm_rst_n),
    .i_pll_release(pll), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(o_dat), .o_wb_ack(ack), .i_cmd_valid(cval),
    .i_cmd(cmd), .o_cmd_ready(crdy), .i_ref_must(rmust), .i_ref_need(1'b0),
    .i_ref_may(1'b0), .i_rdq_pop(pop), .o_iss_valid(ivld), .o_iss(iss), .i_iss_ready(irdy),
    .o_init_busy(busy), .o_self_refresh(sref), .o_dma_req(dma));
  scs_seq_model model (.i_ref_clk(i_ref_clk), .i_stall(stall), .i_iss_valid(ivld),
    .i_iss(iss), .o_iss_ready(irdy), .o_rdq_pop(pop));

  // the clock never stops: the memory may need it running
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    if (ivld && irdy) begin
      got.push_back(iss);
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic conclude;
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic await(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (s !== v && n < 400);
    if (n >= 400) begin
      check(nm, s, v);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    await(ack, 1'b1, "bus ack");
    rdat = o_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic send(input logic w, input logic [31:0] a, input logic [1:0] b);
    @(posedge i_ref_clk);
    cval <= 1'b1;
    cmd <= '{master: 2'h0, wr: w, prio: 3'h3, burst: b, addr: a};
    await(crdy, 1'b1, "cmd ready");
    cval <= 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    wb(1'b0, 8'h20, 32'h0);
    check("starve reset", rdat, 32'h10);
    wb(1'b1, 8'h20, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped", rdat, 32'h0);
  endtask

  // refresh occupies the slot while a write then a read queue up
  task automatic t_order;
    stall <= 1'b1;
    rmust <= 1'b1;
    send(1'b1, 32'h0000_0000, 2'h0);
    send(1'b0, 32'h0000_0800, 2'h0);
    rmust <= 1'b0;
    got.delete();
    stall <= 1'b0;
    repeat (20) @(posedge i_ref_clk);
    check("issues", got.size(), 3);
    check("first", got[0].kind, scs_pkg::SCS_K_REFRESH);
    check("second", got[1].kind, scs_pkg::SCS_K_READ);
    check("second addr", got[1].cmd.addr, 32'h0000_0800);
    check("third", got[2].kind, scs_pkg::SCS_K_WRITE);
  endtask

  task automatic t_status;
    stall <= 1'b1;
    send(1'b1, 32'h0000_1000, 2'h0);
    wb(1'b1, 8'h04, 32'h0);
    got.delete();
    fork
      begin
        repeat (30) @(posedge i_ref_clk);
        stall <= 1'b0;
      end
    join_none
    wb(1'b0, 8'h04, 32'h0);
    check("write before status", got.size(), 1);
    check("status queue", rdat[6:4], 3'h0);
  endtask

  // one command parks in the slot, seven fill the queue
  task automatic t_fill;
    stall <= 1'b1;
    send(1'b1, 32'h0000_5000, 2'h0);
    send(1'b1, 32'h0000_6000, 2'h0);
    send(1'b0, 32'h0000_6004, 2'h0);
    for (int i = 0; i < 5; i++) begin
      send(1'b0, 32'h0000_7000, 2'h0);
    end
    @(posedge i_ref_clk);
    check("ready when full", crdy, 1'b0);
    got.delete();
    stall <= 1'b0;
    repeat (40) @(posedge i_ref_clk);
    check("fill issues", got.size(), 8);
    check("same block write", got[1].cmd.addr, 32'h0000_6000);
    check("same block read", got[2].kind, scs_pkg::SCS_K_READ);
  endtask

  task automatic t_trap;
    for (int b = 0; b < 4; b++) begin
      got.delete();
      send(1'b0, 32'h0000_2000, 2'(b));
      repeat (4) @(posedge i_ref_clk);
      check("burst run", got[0].cmd.burst, (b > 1) ? 2'h0 : 2'(b));
      wb(1'b0, 8'hC0, 32'h0);
      check("trap flag", rdat[0], b > 1);
      wb(1'b1, 8'hC0, 32'h1);
    end
  endtask

  task automatic t_sref;
    wb(1'b1, 8'h0C, 32'hC000_0000);
    repeat (20) @(posedge i_ref_clk);
    check("sref with select", sref, 1'b0);
    wb(1'b1, 8'h0C, 32'h8000_0000);
    await(sref, 1'b1, "sref entry");
    @(posedge i_ref_clk);
    check("sref kind", got[$].kind, scs_pkg::SCS_K_SR_ENTER);
    wb(1'b1, 8'h0C, 32'h0);
    await(sref, 1'b0, "sref exit");
    @(posedge i_ref_clk);
    check("exit kind", got[$].kind, scs_pkg::SCS_K_SR_EXIT);
  endtask

  task automatic t_mreset;
    wb(1'b1, 8'h20, 32'h7);
    stall <= 1'b1;
    send(1'b0, 32'h0000_3000, 2'h0);
    send(1'b0, 32'h0000_4000, 2'h0);
    sm_rst_n <= 1'b0;
    pll <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    sm_rst_n <= 1'b1;
    repeat (150) @(posedge i_ref_clk);
    check("held by release", busy, 1'b1);
    check("issue dropped", ivld, 1'b0);
    pll <= 1'b1;
    stall <= 1'b0;
    await(busy, 1'b0, "init again");
    wb(1'b0, 8'h20, 32'h0);
    check("starve kept", rdat, 32'h7);
    wb(1'b0, 8'h04, 32'h0);
    check("queue dropped", rdat[6:4], 3'h0);
  endtask

  task automatic t_full_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    rst_n <= 1'b1;
    await(busy, 1'b0, "init full");
    wb(1'b0, 8'h20, 32'h0);
    check("starve cleared", rdat, 32'h10);
    check("dma request", dma, 1'b0);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {failures, checks} = '0;
    {rst_n, cyc, stb, we, cval, stall, rmust, adr, wdat} = '0;
    {sm_rst_n, pll} = 2'h3;
    cmd = '0;
    repeat (16) @(posedge i_ref_clk);
    check("ready in reset", crdy, 1'b0);
    rst_n <= 1'b1;
    await(busy, 1'b0, "init");
    t_regs();
    t_order();
    t_status();
    t_fill();
    t_trap();
    t_sref();
    t_mreset();
    t_full_reset();
    conclude();
  end

  // roughly 700 cycles expected; the 20000-cycle limit means a hang
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule

`default_nettype wire
